// *** hw/line_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_out_consts.svh"
// Speed-dependent line clock: toggles every half period for the chosen speed
module line_clk_div
  import mac_out_pkg::*;
#(
  parameter int HALF_HUNDRED = `HALF_HUNDRED,
  parameter int HALF_TEN = `HALF_TEN
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic giga_ref_i,
  input var speed_e speed_i,
  output logic line_clk_o
);
  logic [15:0] cnt_q, cnt_d;
  logic div_q, div_d;
  logic [15:0] limit;

  // Divider: reloads and toggles at the half-period limit
  always_comb begin
    limit = (speed_i == SPD_TEN) ? 16'(HALF_TEN - 1) : 16'(HALF_HUNDRED - 1);
    cnt_d = cnt_q + 16'h0001;
    div_d = div_q;
    if (cnt_q >= limit) begin
      cnt_d = 16'h0000;
      div_d = ~div_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 16'h0000;
      div_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
    end
  end

  // Gigabit passes the 125 MHz reference through, slower rates use the divider
  assign line_clk_o = (speed_i == SPD_GIGA) ? giga_ref_i : div_q;
endmodule
`default_nettype wire

// *** hw/mac_speed_clock_event_outputs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_out_consts.svh"
// Overview of operation
// - Receive line clock runs 125, 25 or 2.5 MHz by link speed.
// - Hundred flag high exactly at 100 Mb/s, from speed field bits 31:30.
// - Low-rate flag high at 10 or 100 Mb/s, low at gigabit.
// - Without management registers, speed comes from vector bits 66:65.
// - Zero-phase copy of the gigabit reference clock is output.
// - Quadrature copy of the reference clock is output for forwarding.
// - Forwarded clocks exist only with shared clocking, at any link speed.
// - Management interrupt comes only from transfer-done through the controller.
// - Timing receive interrupt follows any timing packet received.
// - Timing transmit interrupt follows any timing packet sent.
// - Timing tick interrupt fires every 1/128 second of the clock.
// - Nanoseconds and seconds fields are output, registered.
// - An 8 kHz clock locked to the real-time clock is output.
// - Extra nanoseconds output in the alternate transport format.
// - Transmit line clock uses the same speed-dependent rates.
// - Speed changes apply only at frame start; resets act at once.
module mac_speed_clock_event_outputs
  import mac_out_pkg::*;
#(
  parameter bit HAS_MGMT = 1'b1,
  parameter bit HAS_TIMING = 1'b1,
  parameter bit HAS_SHARED_CLK = 1'b1,
  parameter int HALF_HUNDRED = `HALF_HUNDRED,
  parameter int HALF_TEN = `HALF_TEN,
  parameter int NS_STEP = `NS_PER_SEC / `CORE_CLK_HZ
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic giga_ref_i,
  input wire logic giga_ref_q_i,
  input wire logic [31:0] speed_cfg_i,
  input wire logic [`CFG_VEC_W-1:0] cfg_vec_i,
  input wire logic rx_frame_start_i,
  input wire logic tx_frame_start_i,
  input wire logic xfer_done_i,
  input wire logic xfer_done_en_i,
  input wire logic timing_rx_pkt_i,
  input wire logic timing_tx_pkt_i,
  output logic rx_line_clk_o,
  output logic tx_line_clk_o,
  output logic speed_is_hundred_flag_o,
  output logic speed_is_low_rate_flag_o,
  output logic ref_clock_o,
  output logic ref_clock_quadrature_o,
  output logic mgmt_irq_o,
  output logic timing_rx_irq_o,
  output logic timing_tx_irq_o,
  output logic timing_tick_irq_o,
  output logic [31:0] rtc_nsec_o,
  output logic [31:0] rtc_sec_o,
  output logic [31:0] rtc_nsec_1722_o,
  output logic eight_khz_clock_o
);
  logic [1:0] raw_code;
  speed_e req_speed, rx_speed_q, rx_speed_d, tx_speed_q, tx_speed_d;
  speed_flags_s flags_q, flags_d;
  irq_s irq_q, irq_d;
  rtc_time_s rtc_now, rtc_q, rtc_d;
  logic tick_ev, eightk_raw, eightk_q, eightk_d;
  logic rx_div_clk, tx_div_clk;
  speed_e dir_speed [2];
  wire logic [1:0] dir_clk;

  // Choose the speed field source by build option
  assign raw_code = HAS_MGMT ? speed_cfg_i[`SPEED_REG_HI:`SPEED_REG_LO]
                             : cfg_vec_i[`SPEED_VEC_HI:`SPEED_VEC_LO];

  // Single decode: 0 ten, 1 hundred, anything else gigabit
  always_comb begin
    case (raw_code)
      `SPEED_CODE_TEN: req_speed = SPD_TEN;
      `SPEED_CODE_HUNDRED: req_speed = SPD_HUNDRED;
      default: req_speed = SPD_GIGA;
    endcase
  end

  // Speed is sampled per direction only at that direction's frame start
  always_comb begin
    rx_speed_d = rx_frame_start_i ? req_speed : rx_speed_q;
    tx_speed_d = tx_frame_start_i ? req_speed : tx_speed_q;
    flags_d.hundred = (rx_speed_d == SPD_HUNDRED);
    flags_d.low_rate = (rx_speed_d != SPD_GIGA);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_speed_q <= SPD_GIGA;
      tx_speed_q <= SPD_GIGA;
      flags_q <= '0;
    end else begin
      rx_speed_q <= rx_speed_d;
      tx_speed_q <= tx_speed_d;
      flags_q <= flags_d;
    end
  end

  // Receive and transmit line clock generators, one per direction
  assign dir_speed[0] = rx_speed_q;
  assign dir_speed[1] = tx_speed_q;
  for (genvar g = 0; g < 2; g++) begin : g_dir
    line_clk_div #(
      .HALF_HUNDRED(HALF_HUNDRED),
      .HALF_TEN(HALF_TEN)
    ) u_div (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .giga_ref_i(giga_ref_i),
      .speed_i(dir_speed[g]),
      .line_clk_o(dir_clk[g])
    );
  end
  assign rx_div_clk = dir_clk[0];
  assign tx_div_clk = dir_clk[1];

  // Real-time clock
  rtc_core #(
    .NS_STEP(NS_STEP)
  ) u_rtc (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .time_o(rtc_now),
    .tick_o(tick_ev),
    .eightk_o(eightk_raw)
  );

  // Interrupt levels: mgmt gated by enable, timing pulses gated by build option
  always_comb begin
    irq_d.mgmt = xfer_done_i & xfer_done_en_i;
    irq_d.timing_rx = HAS_TIMING & timing_rx_pkt_i;
    irq_d.timing_tx = HAS_TIMING & timing_tx_pkt_i;
    irq_d.timing_tick = HAS_TIMING & tick_ev;
    rtc_d = HAS_TIMING ? rtc_now : '0;
    eightk_d = HAS_TIMING & eightk_raw;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= '0;
      rtc_q <= '0;
      eightk_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      rtc_q <= rtc_d;
      eightk_q <= eightk_d;
    end
  end

  // Forwarded clocks: plain reference copies, present only with shared clocking
  // Line clocks at gigabit are the reference itself, so not re-registered
  assign ref_clock_o = HAS_SHARED_CLK & giga_ref_i;
  assign ref_clock_quadrature_o = HAS_SHARED_CLK & giga_ref_q_i;
  assign rx_line_clk_o = rx_div_clk;
  assign tx_line_clk_o = tx_div_clk;
  assign speed_is_hundred_flag_o = flags_q.hundred;
  assign speed_is_low_rate_flag_o = flags_q.low_rate;
  assign mgmt_irq_o = irq_q.mgmt;
  assign timing_rx_irq_o = irq_q.timing_rx;
  assign timing_tx_irq_o = irq_q.timing_tx;
  assign timing_tick_irq_o = irq_q.timing_tick;
  assign rtc_nsec_o = rtc_q.nsec;
  assign rtc_sec_o = rtc_q.sec;
  assign rtc_nsec_1722_o = rtc_q.nsec_1722;
  assign eight_khz_clock_o = eightk_q;
endmodule
`default_nettype wire

// *** hw/rtc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_out_consts.svh"
// Free-running real-time clock with tick and 8 kHz events
module rtc_core
  import mac_out_pkg::*;
#(
  parameter int NS_STEP = `NS_PER_SEC / `CORE_CLK_HZ
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  output var rtc_time_s time_o,
  output logic tick_o,
  output logic eightk_o
);
  logic [31:0] ns_q, ns_d, sec_q, sec_d, ns1722_q, ns1722_d;
  logic [31:0] tick_acc_q, tick_acc_d, ek_acc_q, ek_acc_d;
  logic tick_q, tick_d, ek_q, ek_d;

  // Advance nanoseconds, roll seconds, derive tick and 8 kHz each from its own accumulator
  always_comb begin
    ns_d = ns_q + 32'(NS_STEP);
    sec_d = sec_q;
    ns1722_d = ns1722_q + 32'(NS_STEP);
    if (ns_d >= 32'(`NS_PER_SEC)) begin
      ns_d = ns_d - 32'(`NS_PER_SEC);
      sec_d = sec_q + 32'h00000001;
    end
    tick_acc_d = tick_acc_q + 32'(NS_STEP);
    tick_d = 1'b0;
    if (tick_acc_d >= 32'(`TICK_NS)) begin
      tick_acc_d = tick_acc_d - 32'(`TICK_NS);
      tick_d = 1'b1;
    end
    ek_acc_d = ek_acc_q + 32'(NS_STEP);
    ek_d = ek_q;
    if (ek_acc_d >= 32'(`EIGHTK_HALF_NS)) begin
      ek_acc_d = ek_acc_d - 32'(`EIGHTK_HALF_NS);
      ek_d = ~ek_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ns_q <= 32'h00000000;
      sec_q <= 32'h00000000;
      ns1722_q <= 32'h00000000;
      tick_acc_q <= 32'h00000000;
      ek_acc_q <= 32'h00000000;
      tick_q <= 1'b0;
      ek_q <= 1'b0;
    end else begin
      ns_q <= ns_d;
      sec_q <= sec_d;
      ns1722_q <= ns1722_d;
      tick_acc_q <= tick_acc_d;
      ek_acc_q <= ek_acc_d;
      tick_q <= tick_d;
      ek_q <= ek_d;
    end
  end

  // The 1722 format is a free-running nanosecond count that wraps at 2^32
  assign time_o = '{sec: sec_q, nsec: ns_q, nsec_1722: ns1722_q};
  assign tick_o = tick_q;
  assign eightk_o = ek_q;
endmodule
`default_nettype wire

// *** inc/mac_out_consts.svh ***
`ifndef MAC_OUT_CONSTS_SVH
`define MAC_OUT_CONSTS_SVH
// Clock rate of core_clk_i
`define CORE_CLK_HZ 100000000
// Line clock rates in Hz, times ten so the 2.5 MHz figure stays whole
`define LINE_GIGA_HZ_X10 1250000000
`define LINE_HUNDRED_HZ_X10 250000000
`define LINE_TEN_HZ_X10 25000000
// Speed field positions
`define SPEED_REG_HI 31
`define SPEED_REG_LO 30
`define SPEED_VEC_HI 66
`define SPEED_VEC_LO 65
`define CFG_VEC_W 80
// Speed codes
`define SPEED_CODE_TEN 2'h0
`define SPEED_CODE_HUNDRED 2'h1
`define SPEED_CODE_GIGA 2'h2
// Real-time clock fields
`define NS_PER_SEC 1000000000
`define TICK_PER_SEC 128
`define EIGHTK_HZ 8000
// Half period of the 8 kHz clock and full period of the 1/128 s tick, in nanoseconds
`define EIGHTK_HALF_NS 62500
`define TICK_NS 7812500
// Half period of the divided line clocks in core cycles (rounded down)
`define HALF_HUNDRED ((`CORE_CLK_HZ * 10 / `LINE_HUNDRED_HZ_X10) / 2)
`define HALF_TEN ((`CORE_CLK_HZ * 10 / `LINE_TEN_HZ_X10) / 2)
`endif

// *** inc/mac_out_pkg.sv ***
`default_nettype none
package mac_out_pkg;
  typedef enum logic [1:0] {
    SPD_TEN = 2'h0,
    SPD_HUNDRED = 2'h1,
    SPD_GIGA = 2'h3
  } speed_e;
  typedef struct packed {
    logic hundred;
    logic low_rate;
  } speed_flags_s;
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] nsec;
    logic [31:0] nsec_1722;
  } rtc_time_s;
  typedef struct packed {
    logic mgmt;
    logic timing_rx;
    logic timing_tx;
    logic timing_tick;
  } irq_s;
endpackage
`default_nettype wire

// *** verif/mac_out_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_out_consts.svh"
module mac_out_monitor #(
  parameter int NS_STEP = 10
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic giga_ref_i,
  input wire logic giga_ref_q_i,
  input wire logic [31:0] speed_cfg_i,
  input wire logic rx_frame_start_i,
  input wire logic xfer_done_i,
  input wire logic xfer_done_en_i,
  input wire logic timing_rx_pkt_i,
  input wire logic timing_tx_pkt_i,
  input wire logic speed_is_hundred_flag_o,
  input wire logic speed_is_low_rate_flag_o,
  input wire logic ref_clock_o,
  input wire logic ref_clock_quadrature_o,
  input wire logic mgmt_irq_o,
  input wire logic timing_rx_irq_o,
  input wire logic timing_tx_irq_o,
  input wire logic timing_tick_irq_o
);
  localparam int TICK_CYC = `TICK_NS / NS_STEP;
  wire [1:0] flags = {speed_is_hundred_flag_o, speed_is_low_rate_flag_o};
  int gap_q, gap_d;
  logic seen_q, seen_d;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Cycles since the last tick
  always_comb begin
    gap_d = timing_tick_irq_o ? 0 : gap_q + 1;
    seen_d = seen_q | timing_tick_irq_o;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end
  sequence start_s(logic [1:0] c);
    rx_frame_start_i && speed_cfg_i[`SPEED_REG_HI:`SPEED_REG_LO] == c;
  endsequence
  AST_HUNDRED: assert property (start_s(2'h1) |=> flags == 2'h3)
    else $error("hundred code decoded wrong");
  AST_TEN: assert property (start_s(2'h0) |=> flags == 2'h1)
    else $error("ten code decoded wrong");
  AST_GIGA: assert property (start_s(2'h2) |=> flags == 2'h0)
    else $error("gigabit code decoded wrong");
  AST_HOLD: assert property (!rx_frame_start_i |=> $stable(flags))
    else $error("flags moved without frame start");
  AST_REF: assert property (ref_clock_o == giga_ref_i && ref_clock_quadrature_o == giga_ref_q_i)
    else $error("forwarded clock differs");
  AST_MGMT: assert property (1'b1 |=> mgmt_irq_o == $past(xfer_done_i && xfer_done_en_i))
    else $error("management irq wrong");
  AST_RX_IRQ: assert property (1'b1 |=> timing_rx_irq_o == $past(timing_rx_pkt_i))
    else $error("receive timing irq missing");
  AST_TX_IRQ: assert property (1'b1 |=> timing_tx_irq_o == $past(timing_tx_pkt_i))
    else $error("transmit timing irq wrong");
  AST_TICK_GAP: assert property (timing_tick_irq_o && seen_q |-> gap_q == TICK_CYC - 1)
    else $error("tick spacing wrong");
  AST_TICK_DUE: assert property (seen_q |-> gap_q < TICK_CYC)
    else $error("tick overdue");
endmodule
bind mac_speed_clock_event_outputs mac_out_monitor #(.NS_STEP(NS_STEP)) i_mon (
  .core_clk_i, .arst_n_i, .giga_ref_i, .giga_ref_q_i, .speed_cfg_i, .rx_frame_start_i,
  .xfer_done_i, .xfer_done_en_i, .timing_rx_pkt_i, .timing_tx_pkt_i, .speed_is_hundred_flag_o,
  .speed_is_low_rate_flag_o, .ref_clock_o, .ref_clock_quadrature_o, .mgmt_irq_o,
  .timing_rx_irq_o, .timing_tx_irq_o, .timing_tick_irq_o);
`default_nettype wire

// *** verif/mac_out_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Reference clock source and line clock consumer on the user side
module mac_out_user_model (
  input wire logic rx_line_clk_i,
  input wire logic tx_line_clk_i,
  input wire logic eight_khz_clock_i,
  output logic giga_ref_o,
  output logic giga_ref_q_o,
  output var int rx_edges_o,
  output var int tx_edges_o,
  output var int ek_edges_o
);
  // 125 MHz reference and its quarter-period delayed copy
  initial begin
    giga_ref_o = 1'b0;
    forever #4 giga_ref_o = ~giga_ref_o;
  end
  initial begin
    giga_ref_q_o = 1'b0;
    #2;
    forever #4 giga_ref_q_o = ~giga_ref_q_o;
  end
  // Logic clocked from the line clocks and the 8 kHz clock: edge counters
  initial rx_edges_o = 0;
  initial tx_edges_o = 0;
  initial ek_edges_o = 0;
  always @(posedge rx_line_clk_i) rx_edges_o++;
  always @(posedge tx_line_clk_i) tx_edges_o++;
  always @(posedge eight_khz_clock_i) ek_edges_o++;
endmodule
`default_nettype wire

// *** verif/mac_speed_clock_event_outputs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_speed_clock_event_outputs_tb_top;
  localparam int NS_STEP = 12500;
  typedef struct {int sel; logic [31:0] exp;} note_s;
  logic clk = 0, rst_n = 0, rx_st = 0, tx_st = 0, xd = 0, xd_en = 0, prx = 0, ptx = 0;
  logic gref, gref_q, rx_lc, tx_lc, hund, low, rc, rcq, mirq, rirq, tirq, tick, ek;
  logic [31:0] spd = '0, nsec, sec, n1722, seed = 32'h5b;
  logic [79:0] vec = '0;
  int rx_e, tx_e, ek_e, fail_count = 0, comparisons = 0, cyc = 0, ticks = 0;
  int m[4:7];
  note_s q[$];
  event chk_ev;
  string nm[10] = '{"flags", "irq", "nsec", "sec", "rx_rate", "tx_rate", "ticks", "eightk",
    "nsec_1722", "fwd_clk"};
  mac_speed_clock_event_outputs #(.HALF_HUNDRED(2), .HALF_TEN(3), .NS_STEP(NS_STEP)) i_dut (
    .core_clk_i(clk), .arst_n_i(rst_n), .giga_ref_i(gref), .giga_ref_q_i(gref_q),
    .speed_cfg_i(spd), .cfg_vec_i(vec), .rx_frame_start_i(rx_st), .tx_frame_start_i(tx_st),
    .xfer_done_i(xd), .xfer_done_en_i(xd_en), .timing_rx_pkt_i(prx), .timing_tx_pkt_i(ptx),
    .rx_line_clk_o(rx_lc), .tx_line_clk_o(tx_lc), .speed_is_hundred_flag_o(hund),
    .speed_is_low_rate_flag_o(low), .ref_clock_o(rc), .ref_clock_quadrature_o(rcq),
    .mgmt_irq_o(mirq), .timing_rx_irq_o(rirq), .timing_tx_irq_o(tirq),
    .timing_tick_irq_o(tick), .rtc_nsec_o(nsec), .rtc_sec_o(sec), .rtc_nsec_1722_o(n1722),
    .eight_khz_clock_o(ek));
  mac_out_user_model i_user (.rx_line_clk_i(rx_lc), .tx_line_clk_i(tx_lc),
    .eight_khz_clock_i(ek), .giga_ref_o(gref), .giga_ref_q_o(gref_q),
    .rx_edges_o(rx_e), .tx_edges_o(tx_e), .ek_edges_o(ek_e));
  // Clock, cycle and tick counters
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (rst_n) cyc <= cyc + 1;
  always @(posedge clk) if (tick === 1'b1) ticks++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] obs(int sel);
    case (sel)
      0: return {30'h0, hund, low};
      1: return {29'h0, mirq, rirq, tirq};
      2: return nsec;
      3: return sec;
      8: return n1722;
      9: return {30'h0, rc, rcq};
      default: return 32'(m[sel]);
    endcase
  endfunction
  task automatic note(int sel, logic [31:0] exp);
    q.push_back('{sel, exp});
    ->chk_ev;
  endtask
  task automatic wrap_up();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Scoreboard: compares each noted expectation with the outputs
  initial forever begin
    note_s n;
    @(chk_ev);
    while (q.size() > 0) begin
      n = q.pop_front();
      comparisons++;
      if (obs(n.sel) !== n.exp) begin
        fail_count++;
        $display("[FAIL] %s expected %h seen %h", nm[n.sel], n.exp, obs(n.sel));
      end
    end
  end
  // Watchdog
  initial begin
    #60000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    static int fl[4] = '{1, 3, 0, 0};
    static int ed[4] = '{4, 6, 30, 30};
    logic [95:0] t;
    logic [31:0] r;
    repeat (2) @(posedge clk);
    #2 note(0, 0);
    note(1, 0);
    note(2, 0);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      r = rnd();
      t = {rnd(), r, r};
      t[66:65] = ~2'(c);
      spd <= {2'(c), r[29:0]};
      vec <= t[79:0];
      rx_st <= 1'b1;
      tx_st <= 1'b1;
      @(posedge clk);
      rx_st <= 1'b0;
      tx_st <= 1'b0;
      #2 note(0, 32'(fl[c]));
      repeat (8) @(posedge clk);
      #2 m[4] = rx_e;
      m[5] = tx_e;
      repeat (24) @(posedge clk);
      #2 m[4] = rx_e - m[4];
      m[5] = tx_e - m[5];
      note(4, 32'(ed[c]));
      note(5, 32'(ed[c]));
    end
    @(posedge clk);
    spd <= {2'h1, 30'h0};
    repeat (3) @(posedge clk);
    #2 note(0, 0);
    repeat (20) begin
      @(posedge clk);
      r = rnd();
      {xd, xd_en, prx, ptx} <= r[3:0];
      @(posedge clk);
      #2 note(1, {29'h0, r[3] & r[2], r[1], r[0]});
      note(9, {30'h0, gref, gref_q});
    end
    #2 note(2, 32'((cyc - 1) * NS_STEP));
    note(3, 0);
    note(8, 32'((cyc - 1) * NS_STEP));
    m[6] = ticks;
    m[7] = ek_e;
    repeat (1250) @(posedge clk);
    #2 m[6] = ticks - m[6];
    m[7] = ek_e - m[7];
    note(6, 2);
    note(7, 125);
    #1 wrap_up();
  end
endmodule
`default_nettype wire
